// ===== inc/acs_pkg.sv
package acs_pkg;

	// Timing
	localparam int CLK_MHZ = 125;
	localparam int US_PER_MS = 1000;
	localparam int SETTLE_MS = 3000;
	localparam int AUTOZERO_MS = 10;
	localparam int SAVE_MS = 48;
	localparam int CAPTURE_US = 120;
	localparam int OFFSET_US = 110;
	localparam int GAIN_US = 135;
	localparam int MS_TICK_CYC = US_PER_MS * CLK_MHZ;
	localparam int CAPTURE_CYC = CAPTURE_US * CLK_MHZ;
	localparam int OFFSET_CYC = OFFSET_US * CLK_MHZ;
	localparam int GAIN_CYC = GAIN_US * CLK_MHZ;
	localparam int CNT_W = 18;
	localparam int MS_W = 12;

	// Bus map
	localparam int BYTE_W = 8;
	localparam int PIN_W = 4 + 2 + BYTE_W;
	localparam logic [PIN_W-1:0] PIN_IDLE = 14'h3c00;
	localparam logic [1:0] ADDR_OPCODE = 2'h0;
	localparam logic [1:0] ADDR_OPERAND = 2'h1;
	localparam logic [1:0] ADDR_STATUS = 2'h0;
	localparam logic [1:0] ADDR_RES_LO = 2'h1;
	localparam logic [1:0] ADDR_RES_MID = 2'h2;
	localparam logic [1:0] ADDR_RES_HI = 2'h3;
	localparam logic [BYTE_W-1:0] OPERAND_RST = 8'h00;

	// Opcodes
	localparam logic [BYTE_W-1:0] OP_CONV_DEF = 8'h00;
	localparam logic [BYTE_W-1:0] OP_CONV_ADJ = 8'h01;
	localparam logic [BYTE_W-1:0] OP_CAPTURE = 8'h02;
	localparam logic [BYTE_W-1:0] OP_OFS_UP = 8'h03;
	localparam logic [BYTE_W-1:0] OP_OFS_DN = 8'h04;
	localparam logic [BYTE_W-1:0] OP_GAIN_UP = 8'h05;
	localparam logic [BYTE_W-1:0] OP_GAIN_DN = 8'h06;
	localparam logic [BYTE_W-1:0] OP_SAVE = 8'h07;
	localparam logic [BYTE_W-1:0] UNLOCK_KEY = 8'ha5;

	// Result and calibration
	localparam int RES_W = 24;
	localparam int OFS_W = 18;
	localparam int GAIN_W = 12;
	localparam logic [RES_W-1:0] ZERO_CODE = 24'h400000;
	localparam logic [RES_W-1:0] OVL_CODE = 24'hffffff;
	localparam logic [RES_W-1:0] RES_RST = 24'h000000;
	localparam logic signed [OFS_W-1:0] OFS_HI = 18'sh08000;
	localparam logic signed [OFS_W-1:0] OFS_LO = 18'sh38000;
	localparam logic signed [RES_W:0] CAP_HI = 25'sh0008000;
	localparam logic signed [RES_W:0] CAP_LO = 25'sh1ff8000;
	localparam logic [GAIN_W-1:0] GAIN_TOP = 12'hfff;
	localparam logic [GAIN_W-1:0] GAIN_BOT = 12'h000;
	localparam logic [GAIN_W-1:0] NV_GAIN_INIT = 12'h800;
	localparam logic signed [OFS_W-1:0] NV_OFS_INIT = 18'sh00000;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CONV,
		ST_AZ,
		ST_RUN,
		ST_SAVE
	} acs_state_t;

endpackage

// ===== rtl/acs_nv_store.sv
`timescale 1ns/1ns
module acs_nv_store
	import acs_pkg::*;
(
	input wire logic sys_clk, // System clock
	input wire logic rst, // Sync reset
	input wire logic wr_en, // Store request
	input wire logic [GAIN_W-1:0] wr_gain, // Gain to store
	input wire logic signed [OFS_W-1:0] wr_ofs, // Offset to store
	output logic [GAIN_W-1:0] rd_gain, // Stored gain
	output logic signed [OFS_W-1:0] rd_ofs // Stored offset
);

	logic [GAIN_W-1:0] gain_r;
	logic signed [OFS_W-1:0] ofs_r;

	// Stands in for the nonvolatile cells
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			gain_r <= NV_GAIN_INIT;
			ofs_r <= NV_OFS_INIT;
		end else if (wr_en) begin
			gain_r <= wr_gain;
			ofs_r <= wr_ofs;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_gain <= NV_GAIN_INIT;
			rd_ofs <= NV_OFS_INIT;
		end else begin
			rd_gain <= gain_r;
			rd_ofs <= ofs_r;
		end
	end

endmodule

// ===== rtl/acs_cmd_status.sv
`timescale 1ns/1ns
module acs_cmd_status
	import acs_pkg::*;
#(
	parameter int MS_TICK = MS_TICK_CYC,
	parameter int CAPTURE_CYCLES = CAPTURE_CYC,
	parameter int OFFSET_CYCLES = OFFSET_CYC,
	parameter int GAIN_CYCLES = GAIN_CYC
) (
	input wire logic sys_clk, // System clock
	input wire logic rst, // Sync reset, active high
	input wire logic cs_n, // Chip select pin
	input wire logic rd_n, // Read strobe pin
	input wire logic wr_n, // Write strobe pin
	input wire logic [1:0] addr, // Address pins
	input wire logic [BYTE_W-1:0] data_in, // Data pins, input side
	output logic [BYTE_W-1:0] data_out, // Data pins, output side
	output logic data_oe_n, // Low while driving data
	input wire logic conv_trigger_n, // External convert pin
	output logic busy_pin, // Busy pin
	output logic conv_start, // Start pulse to integrator
	output logic conv_adjusted, // Conversion uses adjusted cal
	output logic [GAIN_W-1:0] conv_gain, // Gain for integrator
	input wire logic conv_done, // Integrator finished
	input wire logic conv_overload, // Integrator saw overload
	input wire logic [RES_W-1:0] conv_raw // Raw result
);

	logic [PIN_W-1:0] pins_m_r;
	logic [PIN_W-1:0] pins_s_r;
	logic cs_s, rd_s, wr_s, trig_s;
	logic [1:0] addr_s;
	logic [BYTE_W-1:0] din_s;
	logic wr_d_r, trig_d_r;
	logic wr_rise, op_wr, par_wr, take, ext_start, conv_go;
	logic is_conv_op, is_cal_op, bad_op, key_ok, nv_we;
	logic fault_cond, over_cond, busy_end;
	acs_state_t st_r;
	logic [CNT_W-1:0] cnt_r, run_len, tick_div_r;
	logic [MS_W-1:0] ms_cnt_r, settle_ms_r;
	logic ms_tick;
	logic busy_r, conv_r, ready_r, adj_r;
	logic changed_r, over_r, fault_r, settle_r, chg_pend_r;
	logic [BYTE_W-1:0] operand_r, rd_data_r;
	logic [GAIN_W-1:0] gain_r, nv_gain, conv_gain_r;
	logic signed [OFS_W-1:0] ofs_r, nv_ofs, ofs_step, ofs_up, ofs_dn;
	logic [GAIN_W:0] gain_op, gain_up;
	logic gain_up_hit, gain_dn_hit, ofs_up_hit, ofs_dn_hit;
	logic signed [RES_W:0] cap_val;
	logic cap_ok, init_load_r, conv_start_r;
	logic [RES_W-1:0] result_r, raw_last_r, res_adj, res_def;
	logic [BYTE_W-1:0] status;

	// Pin synchronisers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pins_m_r <= PIN_IDLE;
			pins_s_r <= PIN_IDLE;
		end else begin
			pins_m_r <= {cs_n, rd_n, wr_n, conv_trigger_n, addr, data_in};
			pins_s_r <= pins_m_r;
		end
	end
	assign {cs_s, rd_s, wr_s, trig_s, addr_s, din_s} = pins_s_r;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wr_d_r <= 1'b1;
			trig_d_r <= 1'b1;
		end else begin
			wr_d_r <= wr_s;
			trig_d_r <= trig_s;
		end
	end

	// Write taken at rising edge of the strobe
	assign wr_rise = wr_s & ~wr_d_r & ~cs_s;
	assign op_wr = wr_rise & (addr_s == ADDR_OPCODE);
	assign par_wr = wr_rise & (addr_s == ADDR_OPERAND);
	assign take = op_wr & ~busy_r;
	assign ext_start = ~trig_s & trig_d_r & ~busy_r & ~settle_r;
	assign is_conv_op = (din_s == OP_CONV_DEF) | (din_s == OP_CONV_ADJ);
	assign is_cal_op = (din_s >= OP_CAPTURE) & (din_s <= OP_SAVE);
	assign bad_op = din_s > OP_SAVE;
	assign key_ok = operand_r == UNLOCK_KEY;
	assign conv_go = ext_start | (take & is_conv_op & ~settle_r);
	assign nv_we = take & (din_s == OP_SAVE) & key_ok;

	// Calibration arithmetic
	assign ofs_step = $signed({{(OFS_W-BYTE_W){1'b0}}, operand_r});
	assign ofs_up = ofs_r + ofs_step;
	assign ofs_dn = ofs_r - ofs_step;
	assign ofs_up_hit = ofs_up >= OFS_HI;
	assign ofs_dn_hit = ofs_dn <= OFS_LO;
	assign gain_op = {{(GAIN_W+1-BYTE_W){1'b0}}, operand_r};
	assign gain_up = {1'b0, gain_r} + gain_op;
	assign gain_up_hit = gain_up >= {1'b0, GAIN_TOP};
	assign gain_dn_hit = gain_op >= {1'b0, gain_r};
	assign cap_val = $signed({1'b0, raw_last_r}) - $signed({1'b0, ZERO_CODE});
	assign cap_ok = (cap_val <= CAP_HI) & (cap_val >= CAP_LO);

	always_comb begin
		fault_cond = 1'b0;
		over_cond = 1'b0;
		case (din_s)
			OP_CAPTURE: begin
				fault_cond = ~cap_ok;
				over_cond = ~cap_ok;
			end
			OP_OFS_UP: over_cond = ofs_up_hit;
			OP_OFS_DN: over_cond = ofs_dn_hit;
			OP_GAIN_UP: over_cond = gain_up_hit;
			OP_GAIN_DN: over_cond = gain_dn_hit;
			OP_SAVE: fault_cond = ~key_ok;
			default: fault_cond = bad_op;
		endcase
	end

	always_comb begin
		case (din_s)
			OP_CAPTURE: run_len = CNT_W'(CAPTURE_CYCLES - 1);
			OP_OFS_UP, OP_OFS_DN: run_len = CNT_W'(OFFSET_CYCLES - 1);
			OP_GAIN_UP, OP_GAIN_DN: run_len = CNT_W'(GAIN_CYCLES - 1);
			default: run_len = '0;
		endcase
	end

	// Millisecond tick
	always_ff @(posedge sys_clk) begin
		if (rst || ms_tick) begin
			tick_div_r <= '0;
		end else begin
			tick_div_r <= tick_div_r + 1'b1;
		end
	end
	assign ms_tick = tick_div_r == CNT_W'(MS_TICK - 1);

	// Warm-up settle window
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			settle_r <= 1'b1;
			settle_ms_r <= '0;
		end else if (settle_r && ms_tick) begin
			settle_ms_r <= settle_ms_r + 1'b1;
			if (settle_ms_r == MS_W'(SETTLE_MS - 1)) begin
				settle_r <= 1'b0;
			end
		end
	end

	assign busy_end = ((st_r == ST_RUN) && (cnt_r == '0))
		|| ((st_r == ST_AZ) && ms_tick
		&& (ms_cnt_r == MS_W'(AUTOZERO_MS - 1)))
		|| ((st_r == ST_SAVE) && ms_tick
		&& (ms_cnt_r == MS_W'(SAVE_MS - 1)));

	// Routine sequencer
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r <= ST_IDLE;
			cnt_r <= '0;
			ms_cnt_r <= '0;
		end else begin
			case (st_r)
				ST_IDLE: begin
					ms_cnt_r <= '0;
					if (conv_go) begin
						st_r <= ST_CONV;
					end else if (take && nv_we) begin
						st_r <= ST_SAVE;
					end else if (take) begin
						st_r <= ST_RUN;
						cnt_r <= (fault_cond || is_conv_op) ? '0 : run_len;
					end
				end
				ST_CONV: begin
					if (conv_done) begin
						st_r <= ST_AZ;
					end
				end
				ST_AZ, ST_SAVE: begin
					if (busy_end) begin
						st_r <= ST_IDLE;
					end else if (ms_tick) begin
						ms_cnt_r <= ms_cnt_r + 1'b1;
					end
				end
				ST_RUN: begin
					if (busy_end) begin
						st_r <= ST_IDLE;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	// Status flags; later assignments win, so conv_done beats conv_go, conv_go beats take, take beats busy_end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			busy_r <= 1'b0;
			conv_r <= 1'b0;
			ready_r <= 1'b0;
			adj_r <= 1'b0;
			changed_r <= 1'b0;
			over_r <= 1'b0;
			fault_r <= 1'b0;
			chg_pend_r <= 1'b0;
		end else begin
			if (busy_end) begin
				busy_r <= 1'b0;
				ready_r <= 1'b0;
				chg_pend_r <= 1'b0;
				// Trigger conversions must not clear a pending change flag; conv_go clears chg_pend_r set by a same-cycle calibration opcode
				if (chg_pend_r) begin
					changed_r <= 1'b1;
				end
			end
			if (take) begin
				busy_r <= 1'b1;
				conv_r <= 1'b0;
				ready_r <= 1'b0;
				adj_r <= 1'b0;
				changed_r <= 1'b0;
				over_r <= over_cond;
				fault_r <= fault_cond;
				chg_pend_r <= is_cal_op & ~fault_cond;
			end
			if (conv_go) begin
				busy_r <= 1'b1;
				conv_r <= 1'b1;
				ready_r <= 1'b0;
				adj_r <= ext_start | (din_s == OP_CONV_ADJ);
				chg_pend_r <= 1'b0;
			end
			if (st_r == ST_CONV && conv_done) begin
				conv_r <= 1'b0;
				ready_r <= 1'b1;
				if (conv_overload) begin
					over_r <= 1'b1;
				end
			end
		end
	end

	// Operand and adjusted calibration
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			operand_r <= OPERAND_RST;
			gain_r <= NV_GAIN_INIT;
			ofs_r <= NV_OFS_INIT;
			init_load_r <= 1'b1;
		end else begin
			init_load_r <= 1'b0;
			if (init_load_r) begin
				gain_r <= nv_gain;
				ofs_r <= nv_ofs;
			end
			if (par_wr) begin
				operand_r <= din_s;
			end
			if (take) begin
				case (din_s)
					OP_CAPTURE: if (cap_ok) begin
						ofs_r <= $signed(cap_val[OFS_W-1:0]);
					end
					OP_OFS_UP: ofs_r <= ofs_up_hit ? OFS_HI : ofs_up;
					OP_OFS_DN: ofs_r <= ofs_dn_hit ? OFS_LO : ofs_dn;
					OP_GAIN_UP: gain_r <= gain_up_hit ? GAIN_TOP
						: gain_up[GAIN_W-1:0];
					OP_GAIN_DN: gain_r <= gain_dn_hit ? GAIN_BOT
						: gain_r - gain_op[GAIN_W-1:0];
					default: ;
				endcase
			end
		end
	end

	acs_nv_store u_nv (
		.sys_clk(sys_clk),
		.rst(rst),
		.wr_en(nv_we),
		.wr_gain(gain_r),
		.wr_ofs(ofs_r),
		.rd_gain(nv_gain),
		.rd_ofs(nv_ofs)
	);

	// Result latch
	assign res_adj = conv_raw - {{(RES_W-OFS_W){ofs_r[OFS_W-1]}}, ofs_r};
	// Default conversions use the stored nonvolatile offset
	assign res_def = conv_raw - {{(RES_W-OFS_W){nv_ofs[OFS_W-1]}}, nv_ofs};
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			result_r <= RES_RST;
			raw_last_r <= ZERO_CODE;
		end else if (st_r == ST_CONV && conv_done) begin
			raw_last_r <= conv_raw;
			if (conv_overload) begin
				result_r <= OVL_CODE;
			end else begin
				result_r <= adj_r ? res_adj : res_def;
			end
		end
	end

	// Integrator controls
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			conv_start_r <= 1'b0;
			conv_gain_r <= NV_GAIN_INIT;
		end else begin
			conv_start_r <= conv_go;
			if (conv_go) begin
				conv_gain_r <= (ext_start || din_s == OP_CONV_ADJ)
					? gain_r : nv_gain;
			end
		end
	end
	assign conv_start = conv_start_r;
	assign conv_adjusted = adj_r;
	assign conv_gain = conv_gain_r;
	assign busy_pin = busy_r;

	// Read port; reading has no side effect
	assign status = {settle_r, fault_r, over_r, changed_r,
		adj_r, ready_r, conv_r, busy_r};
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_data_r <= '0;
		end else begin
			case (addr_s)
				ADDR_STATUS: rd_data_r <= status;
				ADDR_RES_LO: rd_data_r <= result_r[BYTE_W-1:0];
				ADDR_RES_MID: rd_data_r <= result_r[RES_W-BYTE_W-1:BYTE_W];
				ADDR_RES_HI: rd_data_r <= result_r[RES_W-1:RES_W-BYTE_W];
				default: rd_data_r <= '0;
			endcase
		end
	end
	assign data_out = rd_data_r;
	assign data_oe_n = cs_s | rd_s;

	property p_busy_set;
		@(posedge sys_clk) disable iff (rst)
		take |=> busy_r && busy_pin;
	endproperty
	a_busy_set: assert property (p_busy_set)
		else $error("busy not set after opcode");

	property p_conv_go;
		@(posedge sys_clk) disable iff (rst)
		conv_go |=> conv_r && conv_start ##1 !conv_start;
	endproperty
	a_conv_go: assert property (p_conv_go)
		else $error("conversion start not flagged");

	property p_ready_end;
		@(posedge sys_clk) disable iff (rst)
		(st_r == ST_AZ) && busy_end |=> !ready_r && !busy_r;
	endproperty
	a_ready_end: assert property (p_ready_end)
		else $error("ready not cleared at busy end");

	property p_adj_ext;
		@(posedge sys_clk) disable iff (rst)
		ext_start |=> adj_r && conv_adjusted;
	endproperty
	a_adj_ext: assert property (p_adj_ext)
		else $error("triggered conversion not adjusted");

	property p_changed;
		@(posedge sys_clk) disable iff (rst)
		busy_end && chg_pend_r |=> changed_r;
	endproperty
	a_changed: assert property (p_changed)
		else $error("cal changed flag missing");

	property p_ovl;
		@(posedge sys_clk) disable iff (rst)
		(st_r == ST_CONV) && conv_done && conv_overload
		|=> over_r && (result_r == OVL_CODE);
	endproperty
	a_ovl: assert property (p_ovl)
		else $error("overload not reported");

	property p_ofs_lim;
		@(posedge sys_clk) disable iff (rst)
		(ofs_r <= OFS_HI) && (ofs_r >= OFS_LO);
	endproperty
	a_ofs_lim: assert property (p_ofs_lim)
		else $error("offset left its range");

	property p_cap_bad;
		@(posedge sys_clk) disable iff (rst)
		take && (din_s == OP_CAPTURE) && !cap_ok
		|=> fault_r && over_r && $stable(ofs_r);
	endproperty
	a_cap_bad: assert property (p_cap_bad)
		else $error("bad capture not refused");

	property p_bad_op;
		@(posedge sys_clk) disable iff (rst)
		take && bad_op |=> fault_r && !conv_r ##1 !busy_r;
	endproperty
	a_bad_op: assert property (p_bad_op)
		else $error("illegal opcode not faulted");

	property p_key;
		@(posedge sys_clk) disable iff (rst)
		take && (din_s == OP_SAVE) && !key_ok |-> !nv_we ##1 fault_r;
	endproperty
	a_key: assert property (p_key)
		else $error("save without key accepted");

	property p_settle;
		@(posedge sys_clk) disable iff (rst)
		settle_r |-> !conv_go;
	endproperty
	a_settle: assert property (p_settle)
		else $error("conversion during settle");

	c_conv: cover property (@(posedge sys_clk) disable iff (rst)
		conv_go ##1 conv_r);
	c_ext: cover property (@(posedge sys_clk) disable iff (rst)
		ext_start);
	c_save: cover property (@(posedge sys_clk) disable iff (rst)
		nv_we);

endmodule

// ===== verification/acs_host_model.sv
`timescale 1ns/1ns
module acs_host_model
	import acs_pkg::*;
(
	input wire logic sys_clk, // System clock
	output logic cs_n, // Chip select
	output logic rd_n, // Read strobe
	output logic wr_n, // Write strobe
	output logic [1:0] addr, // Address lines
	output logic [BYTE_W-1:0] data_in, // Bus toward device
	input wire logic [BYTE_W-1:0] data_out, // Bus from device
	input wire logic data_oe_n // Device drives bus
);
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		addr = 2'h0;
		data_in = 8'h00;
	end

	task automatic edges(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// Address and data settle first, then a low-high write strobe
	task automatic write(input logic [1:0] a, input logic [BYTE_W-1:0] d);
		addr = a;
		data_in = d;
		cs_n = 1'b0;
		edges(4);
		wr_n = 1'b0;
		edges(4);
		wr_n = 1'b1;
		edges(4);
		cs_n = 1'b1;
		data_in = ~d; // Released bus floats away from last value
		edges(4);
	endtask

	task automatic read(input logic [1:0] a, output logic [BYTE_W-1:0] d);
		addr = a;
		cs_n = 1'b0;
		rd_n = 1'b0;
		edges(5);
		// Sampled just after the edge, once read data has settled
		d = data_oe_n ? 8'hxx : data_out;
		rd_n = 1'b1;
		cs_n = 1'b1;
		edges(3);
	endtask
endmodule

// ===== verification/acs_cmd_status_tb.sv
`timescale 1ns/1ns
module acs_cmd_status_tb
	import acs_pkg::*;
;
	logic sys_clk, rst, cs_n, rd_n, wr_n, data_oe_n, busy_pin;
	logic conv_trigger_n, conv_start, conv_adjusted, conv_done;
	logic conv_overload;
	logic [1:0] addr;
	logic [BYTE_W-1:0] data_in, data_out, st;
	logic [GAIN_W-1:0] conv_gain;
	logic [RES_W-1:0] conv_raw, raw_v, res;
	int errors = 0;
	int checked = 0;
	int int_cnt = 0;
	int starts = 0;

	acs_cmd_status #(.MS_TICK(10), .CAPTURE_CYCLES(8), .OFFSET_CYCLES(6),
		.GAIN_CYCLES(10)) dut (
		.sys_clk(sys_clk),
		.rst(rst),
		.cs_n(cs_n),
		.rd_n(rd_n),
		.wr_n(wr_n),
		.addr(addr),
		.data_in(data_in),
		.data_out(data_out),
		.data_oe_n(data_oe_n),
		.conv_trigger_n(conv_trigger_n),
		.busy_pin(busy_pin),
		.conv_start(conv_start),
		.conv_adjusted(conv_adjusted),
		.conv_gain(conv_gain),
		.conv_done(conv_done),
		.conv_overload(conv_overload),
		.conv_raw(conv_raw)
	);

	acs_host_model hm (
		.sys_clk(sys_clk),
		.cs_n(cs_n),
		.rd_n(rd_n),
		.wr_n(wr_n),
		.addr(addr),
		.data_in(data_in),
		.data_out(data_out),
		.data_oe_n(data_oe_n)
	);

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// Integrator stand-in: done 20 cycles after each start
	assign conv_raw = conv_done ? raw_v : ~raw_v;
	always @(posedge sys_clk) begin
		conv_done <= #1 (int_cnt == 1);
		if (conv_start === 1'b1) begin
			int_cnt <= 20;
			starts <= starts + 1;
		end else if (int_cnt != 0) begin
			int_cnt <= int_cnt - 1;
		end
	end

	task automatic conclude;
		if (errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [RES_W-1:0] exp, got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic op_st(input logic [7:0] code, input logic [7:0] exp);
		int n;
		n = 0;
		hm.write(ADDR_OPCODE, code);
		while (busy_pin !== 1'b0 && n < 2000) begin
			hm.edges(1);
			n++;
		end
		hm.read(ADDR_STATUS, st);
		chk("status", exp, st);
	endtask

	task automatic conv(input logic trig, input logic [7:0] code,
		input logic [23:0] raw, input logic ovl, input logic [7:0] sticky,
		input logic [23:0] exp);
		logic [7:0] adj;
		int n;
		adj = (trig || code == OP_CONV_ADJ) ? 8'h08 : 8'h00;
		raw_v = raw;
		conv_overload = ovl;
		if (trig) begin
			conv_trigger_n = 1'b0;
			hm.edges(4);
			conv_trigger_n = 1'b1;
			hm.edges(4);
		end else begin
			hm.write(ADDR_OPCODE, code);
		end
		hm.read(ADDR_STATUS, st);
		chk("status converting", 8'h03 | adj | sticky, st);
		chk("adjusted pin", adj[3], conv_adjusted);
		n = 0;
		while (st[2] !== 1'b1 && n < 20) begin
			hm.read(ADDR_STATUS, st);
			n++;
		end
		chk("status ready", 8'h05 | adj | sticky | (ovl ? 8'h20 : 8'h00), st);
		hm.read(ADDR_RES_LO, res[7:0]);
		hm.read(ADDR_RES_MID, res[15:8]);
		hm.read(ADDR_RES_HI, res[23:16]);
		chk("result", exp, res);
		n = 0;
		while (busy_pin !== 1'b0 && n < 200) begin
			hm.edges(1);
			n++;
		end
		chk("auto-zero span", 1, n > 45 && n < 80);
		hm.read(ADDR_STATUS, st);
		chk("status done", sticky | (ovl ? 8'h20 : 8'h00), st & 8'hf7);
	endtask

	task automatic t_settle;
		int s, n;
		hm.read(ADDR_STATUS, st);
		chk("reset status", 8'h80, st);
		chk("busy pin", 0, busy_pin);
		s = starts;
		hm.write(ADDR_OPCODE, OP_CONV_ADJ);
		hm.edges(30);
		chk("starts in settle", s, starts);
		hm.read(ADDR_STATUS, st);
		chk("settle status", 8'h80, st);
		n = 0;
		while (st[7] !== 1'b0 && n < 6000) begin
			hm.read(ADDR_STATUS, st);
			n++;
		end
		chk("settled status", 8'h00, st);
	endtask

	task automatic t_cal;
		for (int i = 0; i < 2; i++) op_st(i ? 8'hff : 8'h08, 8'h40);
		conv(0, OP_CONV_DEF, 24'h400010, 0, 0, 24'h400010);
		chk("default gain", NV_GAIN_INIT, conv_gain);
		op_st(OP_CAPTURE, 8'h10);
		conv(0, OP_CONV_ADJ, 24'h400100, 0, 0, 24'h4000f0);
		conv(0, OP_CONV_DEF, 24'h400100, 0, 0, 24'h400100);
		hm.write(ADDR_OPERAND, 8'h05);
		op_st(OP_OFS_UP, 8'h10);
		op_st(OP_OFS_DN, 8'h10);
		op_st(OP_OFS_DN, 8'h10);
		conv(0, OP_CONV_ADJ, 24'h400100, 0, 0, 24'h4000f5);
	endtask

	task automatic t_limits;
		conv(0, OP_CONV_DEF, 24'h500000, 0, 0, 24'h500000);
		op_st(OP_CAPTURE, 8'h60);
		conv(0, OP_CONV_ADJ, 24'h400100, 0, 0, 24'h4000f5);
		hm.write(ADDR_OPERAND, 8'hff);
		for (int i = 0; i < 10; i++) op_st(OP_GAIN_UP, i < 8 ? 8'h10 : 8'h30);
		conv(0, OP_CONV_ADJ, 24'h400100, 0, 0, 24'h4000f5);
		chk("saturated gain", GAIN_TOP, conv_gain);
	endtask

	task automatic t_save;
		hm.write(ADDR_OPERAND, 8'h00);
		op_st(OP_SAVE, 8'h40);
		hm.write(ADDR_OPERAND, UNLOCK_KEY);
		op_st(OP_SAVE, 8'h10);
		conv(0, OP_CONV_DEF, 24'h400000, 0, 0, 24'h3ffff5);
		chk("saved gain", GAIN_TOP, conv_gain);
	endtask

	task automatic t_overload;
		conv(0, OP_CONV_ADJ, 24'h123456, 1, 0, OVL_CODE);
		hm.read(ADDR_STATUS, st);
		chk("sticky over", 8'h20, st & 8'hf7);
		op_st(OP_OFS_UP, 8'h10);
		op_st(OP_GAIN_DN, 8'h10);
		conv(1, 8'h00, 24'h400100, 0, 8'h10, 24'h400050);
		chk("lowered gain", 12'hf5a, conv_gain);
	endtask

	initial begin
		rst = 1'b1;
		conv_trigger_n = 1'b1;
		conv_overload = 1'b0;
		raw_v = 24'h000000;
		repeat (10) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		hm.edges(1);
		t_settle;
		t_cal;
		t_limits;
		t_save;
		t_overload;
		conclude;
	end

	initial begin
		repeat (100000) @(posedge sys_clk);
		errors++;
		conclude;
	end
endmodule
